/* File: hw/plp_defs.svh */
`ifndef PLP_DEFS_SVH
`define PLP_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PLP_ADDR_W 3
`define PLP_OFF_DATA 3'h0
`define PLP_OFF_STAT 3'h1
`define PLP_OFF_CTRL 3'h2
`define PLP_OFF_ISR 3'h3
`define PLP_OFF_IMR 3'h4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PLP_CTRL_W 5
`define PLP_CTRL_STROBE 0
`define PLP_CTRL_FEED 1
`define PLP_CTRL_INIT 2
`define PLP_CTRL_SELECT 3
`define PLP_CTRL_IRQEN 4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define PLP_STAT_ERR 3
`define PLP_STAT_SEL 4
`define PLP_STAT_PAPER 5
`define PLP_STAT_ACK 6
`define PLP_STAT_BUSY 7

// ----------------------------------------
// event bits and reset values
// ----------------------------------------
`define PLP_EV_W 1
`define PLP_EV_ACK 0
`define PLP_CTRL_RST 5'h00
`define PLP_DATA_RST 8'h00
`define PLP_IMR_RST 1'h1
`define PLP_PINS_RST 5'h09
`define PLP_DRV_RST 1'h1

`endif

/* File: hw/plp_pkg.sv */
package plp_pkg;

	// printer status pins, as seen on the cable
	typedef struct packed {
		logic busy;
		logic ack;
		logic paper_out;
		logic printer_selected_in;
		logic error_n;
	} plp_status_t;

	// open-drain control pins, one bit each
	typedef struct packed {
		logic printer_select_out;
		logic init;
		logic auto_feed;
		logic data_latch_strobe;
	} plp_ctl_pins_t;

endpackage

/* File: hw/plp_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
// a bit changes only once stages two and three agree
module plp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;
	logic [W-1:0] out_next;

	always_comb begin
		out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			out_reg <= RST_VAL;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;

endmodule // plp_sync

/* File: hw/plp_sticky.sv */
`timescale 1ns/1ps
// ----------------------------------------
// sticky event bits, write one to clear
// ----------------------------------------
// set wins over a clear in the same cycle so no event is lost
module plp_sticky #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		q_next = (q_reg & ~clr) | set;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule // plp_sticky

/* File: hw/printer_parallel_port.sv */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "plp_defs.svh"
module printer_parallel_port (
	input wire logic mclk,
	input wire logic rst,
	input wire logic port_chip_select,
	input wire logic [`PLP_ADDR_W-1:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_write_strobe,
	input wire logic host_read_strobe,
	output logic [7:0] host_rdata,
	output logic printer_irq_o,
	output logic printer_irq_oe_n,
	input wire logic port_drive_enable,
	input wire logic [7:0] port_data_lines_i,
	output logic [7:0] port_data_lines_o,
	output logic port_data_lines_oe_n,
	input wire plp_pkg::plp_status_t printer_status,
	output plp_pkg::plp_ctl_pins_t printer_ctl_o,
	output plp_pkg::plp_ctl_pins_t printer_ctl_oe_n
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	plp_pkg::plp_status_t status_s;
	logic drive_s;
	logic [7:0] data_in_s;

	// printer keeps its own line meanings; only sampled here
	plp_sync #(
		.W(6),
		.RST_VAL({`PLP_DRV_RST, `PLP_PINS_RST})
	) u_sync_ctl (
		.mclk(mclk),
		.rst(rst),
		.din({port_drive_enable, printer_status}),
		.dout({drive_s, status_s})
	);

	plp_sync #(
		.W(8),
		.RST_VAL(8'h00)
	) u_sync_data (
		.mclk(mclk),
		.rst(rst),
		.din(port_data_lines_i),
		.dout(data_in_s)
	);

	// ----------------------------------------
	// host access decode
	// ----------------------------------------
	logic wr_ev;
	logic rd_ev;

	assign wr_ev = port_chip_select && host_write_strobe;
	assign rd_ev = port_chip_select && host_read_strobe;

	// ----------------------------------------
	// acknowledge edge and event bits
	// ----------------------------------------
	logic ack_prev_reg;
	logic ack_prev_next;
	logic ack_rise;
	logic [`PLP_EV_W-1:0] ev_set;
	logic [`PLP_EV_W-1:0] ev_clr;
	logic [`PLP_EV_W-1:0] isr;

	always_comb begin
		ack_prev_next = status_s.ack;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_prev_reg <= 1'h1;
		end else begin
			ack_prev_reg <= ack_prev_next;
		end
	end

	// ack idles high; the end of the low pulse is the event
	assign ack_rise = status_s.ack && !ack_prev_reg;

	always_comb begin
		ev_set = '0;
		ev_set[`PLP_EV_ACK] = ack_rise;
		ev_clr = '0;
		if (wr_ev && host_addr == `PLP_OFF_ISR) begin
			ev_clr = host_wdata[`PLP_EV_W-1:0];
		end
	end

	plp_sticky #(
		.W(`PLP_EV_W)
	) u_isr (
		.mclk(mclk),
		.rst(rst),
		.set(ev_set),
		.clr(ev_clr),
		.q(isr)
	);

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic [`PLP_CTRL_W-1:0] ctrl_reg;
	logic [`PLP_CTRL_W-1:0] ctrl_next;
	logic [`PLP_EV_W-1:0] imr_reg;
	logic [`PLP_EV_W-1:0] imr_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] stat_word;
	logic [7:0] data_view;

	always_comb begin
		stat_word = 8'h00;
		stat_word[`PLP_STAT_ERR] = status_s.error_n;
		stat_word[`PLP_STAT_SEL] = status_s.printer_selected_in;
		stat_word[`PLP_STAT_PAPER] = status_s.paper_out;
		stat_word[`PLP_STAT_ACK] = status_s.ack;
		stat_word[`PLP_STAT_BUSY] = status_s.busy;
		// released lines read what the outside drives
		data_view = drive_s ? data_in_s : data_reg;
	end

	always_comb begin
		data_next = data_reg;
		ctrl_next = ctrl_reg;
		imr_next = imr_reg;
		if (wr_ev) begin
			case (host_addr)
				`PLP_OFF_DATA: begin
					data_next = host_wdata;
				end
				`PLP_OFF_CTRL: begin
					ctrl_next = host_wdata[`PLP_CTRL_W-1:0];
				end
				`PLP_OFF_IMR: begin
					imr_next = host_wdata[`PLP_EV_W-1:0];
				end
				default: begin
					data_next = data_reg;
				end
			endcase
		end
	end

	always_comb begin
		rdata_next = 8'h00;
		if (rd_ev) begin
			case (host_addr)
				`PLP_OFF_DATA: begin
					rdata_next = data_view;
				end
				`PLP_OFF_STAT: begin
					rdata_next = stat_word;
				end
				`PLP_OFF_CTRL: begin
					rdata_next = {{(8-`PLP_CTRL_W){1'b0}}, ctrl_reg};
				end
				`PLP_OFF_ISR: begin
					rdata_next = {{(8-`PLP_EV_W){1'b0}}, isr};
				end
				`PLP_OFF_IMR: begin
					rdata_next = {{(8-`PLP_EV_W){1'b0}}, imr_reg};
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			data_reg <= `PLP_DATA_RST;
			ctrl_reg <= `PLP_CTRL_RST;
			imr_reg <= `PLP_IMR_RST;
			rdata_reg <= 8'h00;
		end else begin
			data_reg <= data_next;
			ctrl_reg <= ctrl_next;
			imr_reg <= imr_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	logic irq_reg;
	logic irq_next;
	logic irq_oe_n_reg;
	logic irq_oe_n_next;
	logic data_oe_n_reg;
	logic data_oe_n_next;
	plp_pkg::plp_ctl_pins_t ctl_oe_n_reg;
	plp_pkg::plp_ctl_pins_t ctl_oe_n_next;

	always_comb begin
		irq_next = ctrl_reg[`PLP_CTRL_IRQEN] && |(isr & imr_reg);
		// floating rather than low lets several sources share a line
		irq_oe_n_next = !ctrl_reg[`PLP_CTRL_IRQEN];
		data_oe_n_next = drive_s;
		// open drain: enable the low level, else the pullup wins
		ctl_oe_n_next.data_latch_strobe =
			!ctrl_reg[`PLP_CTRL_STROBE];
		ctl_oe_n_next.auto_feed = !ctrl_reg[`PLP_CTRL_FEED];
		ctl_oe_n_next.init = !ctrl_reg[`PLP_CTRL_INIT];
		ctl_oe_n_next.printer_select_out =
			!ctrl_reg[`PLP_CTRL_SELECT];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_reg <= 1'h0;
			irq_oe_n_reg <= 1'h1;
			data_oe_n_reg <= 1'h1;
			ctl_oe_n_reg <= 4'hF;
		end else begin
			irq_reg <= irq_next;
			irq_oe_n_reg <= irq_oe_n_next;
			data_oe_n_reg <= data_oe_n_next;
			ctl_oe_n_reg <= ctl_oe_n_next;
		end
	end

	assign host_rdata = rdata_reg;
	assign printer_irq_o = irq_reg;
	assign printer_irq_oe_n = irq_oe_n_reg;
	assign port_data_lines_o = data_reg;
	assign port_data_lines_oe_n = data_oe_n_reg;
	assign printer_ctl_o = 4'h0;
	assign printer_ctl_oe_n = ctl_oe_n_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_irq_rise;
		@(posedge mclk) disable iff (rst)
		(ack_rise && ctrl_reg[`PLP_CTRL_IRQEN] && imr_reg[`PLP_EV_ACK]
			&& !wr_ev) |-> ##2 printer_irq_o;
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("ack rise did not raise interrupt");

	property p_irq_gate;
		@(posedge mclk) disable iff (rst)
		!ctrl_reg[`PLP_CTRL_IRQEN] |=> !printer_irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt high while disabled");

	property p_irq_float;
		@(posedge mclk) disable iff (rst)
		!ctrl_reg[`PLP_CTRL_IRQEN] |=> printer_irq_oe_n;
	endproperty
	a_irq_float: assert property (p_irq_float)
		else $error("interrupt driven while disabled");

	property p_drive;
		@(posedge mclk) disable iff (rst)
		!drive_s |=> !port_data_lines_oe_n;
	endproperty
	a_drive: assert property (p_drive)
		else $error("data lines not driven");

	property p_release;
		@(posedge mclk) disable iff (rst)
		drive_s |=> port_data_lines_oe_n;
	endproperty
	a_release: assert property (p_release)
		else $error("data lines not released");

	property p_data_in;
		@(posedge mclk) disable iff (rst)
		(rd_ev && host_addr == `PLP_OFF_DATA && drive_s)
			|=> host_rdata == $past(data_in_s);
	endproperty
	a_data_in: assert property (p_data_in)
		else $error("released port read wrong");

	property p_ctl_pins;
		@(posedge mclk) disable iff (rst)
		ctrl_reg[`PLP_CTRL_STROBE] ##1 ctrl_reg[`PLP_CTRL_STROBE]
			|-> !printer_ctl_oe_n.data_latch_strobe
			&& printer_ctl_oe_n.init == !$past(ctrl_reg[`PLP_CTRL_INIT]);
	endproperty
	a_ctl_pins: assert property (p_ctl_pins)
		else $error("strobe or init pin wrong");

	property p_sel_feed;
		@(posedge mclk) disable iff (rst)
		##1 printer_ctl_oe_n.printer_select_out ==
			!$past(ctrl_reg[`PLP_CTRL_SELECT])
			&& printer_ctl_oe_n.auto_feed == !$past(ctrl_reg[`PLP_CTRL_FEED]);
	endproperty
	a_sel_feed: assert property (p_sel_feed)
		else $error("select or feed pin wrong");

	property p_write_read;
		@(posedge mclk) disable iff (rst)
		(wr_ev && host_addr == `PLP_OFF_CTRL) ##1 (rd_ev
			&& host_addr == `PLP_OFF_CTRL && !wr_ev)
			|=> host_rdata == {3'h0, $past(host_wdata[4:0], 2)};
	endproperty
	a_write_read: assert property (p_write_read)
		else $error("control readback mismatch");

	property p_no_cs;
		@(posedge mclk) disable iff (rst)
		!port_chip_select |=> $stable(ctrl_reg) && $stable(data_reg)
			&& host_rdata == 8'h00;
	endproperty
	a_no_cs: assert property (p_no_cs)
		else $error("access without chip select");

	property p_reset;
		@(posedge mclk)
		rst |=> ctrl_reg == `PLP_CTRL_RST && !printer_irq_o
			&& port_data_lines_oe_n && printer_irq_oe_n;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset state wrong");

	c_irq: cover property (@(posedge mclk) disable iff (rst)
		ack_rise ##2 printer_irq_o);
	c_clear: cover property (@(posedge mclk) disable iff (rst)
		printer_irq_o ##1 (wr_ev && host_addr == `PLP_OFF_ISR)
		##2 !printer_irq_o);
	c_input: cover property (@(posedge mclk) disable iff (rst)
		rd_ev && drive_s && host_addr == `PLP_OFF_DATA);

endmodule // printer_parallel_port

/* File: testbench/plp_printer_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// printer on the far side of the port
// ----------------------------------------
module plp_printer_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic strobe_pin,
	input wire logic paper_out,
	input wire logic selected,
	input wire logic error,
	output plp_pkg::plp_status_t status
);
	logic [3:0] cnt_reg;
	// ack held low eight cycles, four times what the pin filter needs
	always_ff @(posedge mclk) begin
		if (rst)
			cnt_reg <= 4'h0;
		else if (cnt_reg == 4'h0 && !strobe_pin)
			cnt_reg <= 4'h1;
		else if (cnt_reg != 4'h0 && cnt_reg != 4'hF)
			cnt_reg <= cnt_reg + 4'h1;
		else if (cnt_reg == 4'hF && strobe_pin)
			cnt_reg <= 4'h0;
	end
	assign status.busy = cnt_reg != 4'h0;
	assign status.ack = !(cnt_reg >= 4'h4 && cnt_reg < 4'hC);
	assign status.paper_out = paper_out;
	assign status.printer_selected_in = selected;
	assign status.error_n = !error;
endmodule // plp_printer_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic mclk, rst, cs, we, re, drv_en, irq, irq_oe_n, pd_oe_n;
	logic po, sel, err;
	logic [2:0] addr;
	logic [7:0] wd, rdata, pd_o, pd_i, pat, d, c, r;
	plp_pkg::plp_status_t st;
	plp_pkg::plp_ctl_pins_t ctl_o, ctl_oe;
	int n_mismatch, tests_run, i;
	logic strobe_pin;

	assign pd_i = pd_oe_n ? pat : pd_o;
	assign strobe_pin = ctl_oe.data_latch_strobe ? 1'b1 :
		ctl_o.data_latch_strobe;

	printer_parallel_port dut (.mclk(mclk), .rst(rst),
		.port_chip_select(cs), .host_addr(addr), .host_wdata(wd),
		.host_write_strobe(we), .host_read_strobe(re),
		.host_rdata(rdata), .printer_irq_o(irq),
		.printer_irq_oe_n(irq_oe_n), .port_drive_enable(drv_en),
		.port_data_lines_i(pd_i), .port_data_lines_o(pd_o),
		.port_data_lines_oe_n(pd_oe_n), .printer_status(st),
		.printer_ctl_o(ctl_o), .printer_ctl_oe_n(ctl_oe));
	plp_printer_model printer (.mclk(mclk), .rst(rst),
		.strobe_pin(strobe_pin), .paper_out(po), .selected(sel),
		.error(err), .status(st));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] exp_stat(logic p, logic s, logic e);
		return {2'h1, p, s, !e, 3'h0};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic s, input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		cs <= s;
		addr <= a;
		wd <= v;
		we <= 1'b1;
		@(posedge mclk);
		we <= 1'b0;
		cs <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk);
		cs <= 1'b1;
		addr <= a;
		re <= 1'b1;
		@(posedge mclk);
		re <= 1'b0;
		cs <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_irq(input logic lvl);
		for (i = 0; i < 60 && irq !== lvl; i++)
			@(posedge mclk) #1;
		chk({7'h00, irq}, {7'h00, lvl});
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#(25 * 20000);
		n_mismatch++;
		finish_test;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, cs, we, re, po, sel, err} = 7'h40;
		drv_en = 1'b1;
		addr = 3'h0;
		wd = 8'h00;
		pat = 8'h00;
		n_mismatch = 0;
		tests_run = 0;
		void'($urandom(12718));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({irq_oe_n, pd_oe_n, irq, rdata[0], ctl_oe}, 8'hCF);
		chk(pd_o, 8'h00);
		for (int k = 0; k < 8; k++) begin
			d = 8'($urandom);
			c = 8'($urandom) & 8'h0F;
			wr(1'b1, 3'h0, d);
			wr(1'b1, 3'h2, c);
			@(posedge mclk);
			#1 chk({ctl_o, ctl_oe}, {4'h0, ~c[3:0]});
			rd(3'h2, r);
			chk(r, c);
			chk({7'h00, irq_oe_n}, 8'h01);
			@(posedge mclk);
			drv_en <= k[0];
			pat <= 8'($urandom);
			repeat (8) @(posedge mclk);
			#1 chk({7'h00, pd_oe_n}, {7'h00, k[0]});
			if (!k[0])
				chk(pd_o, d);
			rd(3'h0, r);
			chk(r, k[0] ? pat : d);
			{po, sel, err} <= 3'($urandom);
			wr(1'b0, 3'h0, ~d);
			wr(1'b1, 3'h2, 8'h00);
			repeat (30) @(posedge mclk);
			rd(3'h1, r);
			chk(r, exp_stat(po, sel, err));
			rd(3'h0, r);
			chk(r, k[0] ? pat : d);
			rd(3'h5 + k[1:0] % 3, r);
			chk(r, 8'h00);
		end
		wr(1'b1, 3'h3, 8'h01);
		wr(1'b1, 3'h2, 8'h11);
		wr(1'b1, 3'h2, 8'h10);
		repeat (4) @(posedge mclk);
		rd(3'h1, r);
		chk(r & 8'h80, 8'h80);
		wait_irq(1'b1);
		chk({7'h00, irq_oe_n}, 8'h00);
		rd(3'h3, r);
		chk(r, 8'h01);
		wr(1'b1, 3'h4, 8'h00);
		wait_irq(1'b0);
		wr(1'b1, 3'h4, 8'h01);
		wait_irq(1'b1);
		wr(1'b1, 3'h3, 8'h01);
		wait_irq(1'b0);
		wr(1'b1, 3'h2, 8'h01);
		wr(1'b1, 3'h2, 8'h00);
		repeat (40) @(posedge mclk);
		#1 chk({6'h00, irq_oe_n, irq}, 8'h02);
		rd(3'h3, r);
		chk(r, 8'h01);
		finish_test;
	end
endmodule // tb
